// File: src/smc_top.sv
// Serdes mode control: pin decode, lane status outputs and register port
`timescale 1ns/1ps
`default_nettype none
module smc_top (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic coding_enable_i,
  input wire logic op_mode_select_bit0_i,
  input wire logic op_mode_select_bit1_i,
  input wire logic standby_i,
  input wire logic [smc_pkg::NCH-1:0] serial_loopback_enable_i,
  input wire logic pattern_test_enable_i,
  input wire logic lane_clock_sync_i,
  input wire logic chip_reset_low_i,
  input wire logic comma_align_enable_i,
  input wire logic factory_test_enable_i,
  input wire logic signal_type_hstl_i,
  input wire logic [smc_pkg::NCH-1:0] loss_of_signal_i,
  input wire logic [smc_pkg::NCH-1:0] comma_found_i,
  input wire logic [smc_pkg::NCH-1:0] pattern_check_pass_i,
  input wire logic [smc_pkg::NCH-1:0] tx_control_char_request_i,
  input wire logic [smc_pkg::NCH-1:0] tx_tenth_bit_i,
  input wire logic [smc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic encoder_enable_o,
  output logic decoder_enable_o,
  output logic tx_path_enable_o,
  output logic rx_path_enable_o,
  output logic repeater_o,
  output logic low_power_o,
  output logic [smc_pkg::NCH-1:0] loopback_o,
  output logic pattern_gen_enable_o,
  output logic pattern_check_enable_o,
  output logic tx_clock_from_lane_a_o,
  output logic rx_clock_from_lane_a_o,
  output logic buffer_recenter_o,
  output logic comma_align_o,
  output logic [smc_pkg::NCH-1:0] tx_kchar_o,
  output logic [smc_pkg::NCH-1:0] tx_raw_bit8_o,
  output logic [smc_pkg::NCH-1:0] tx_raw_bit9_o,
  output logic [smc_pkg::NCH-1:0] multifunction_output_o,
  output logic irq_o
);
  import smc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] pins;
    smc_mode_e mode;
    logic [7:0] mf_sel;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [NCH-1:0] prev_los;
    logic [NCH-1:0] prev_comma;
    logic [NCH-1:0] prev_fail;
    logic enc;
    logic txp;
    logic rxp;
    logic rpt;
    logic lowp;
    logic [NCH-1:0] loop;
    logic pat;
    logic sync;
    logic recenter;
    logic comma;
    logic [NCH-1:0] kchar;
    logic [NCH-1:0] raw8;
    logic [NCH-1:0] raw9;
    logic [NCH-1:0] mf;
    logic irq;
    logic [31:0] rdata;
  } smc_state_s;

  localparam smc_state_s RESET_STATE = '{
    s1: PIN_DEFAULT, s2: PIN_DEFAULT, s3: PIN_DEFAULT, pins: PIN_DEFAULT,
    mode: SMC_MODE_TRX, mf_sel: MF_SEL_RESET, irq_stat: 12'h000, irq_en: 12'h000,
    prev_los: 4'h0, prev_comma: 4'h0, prev_fail: 4'h0,
    enc: 1'b1, txp: 1'b1, rxp: 1'b1, rpt: 1'b0, lowp: 1'b0, loop: 4'h0,
    pat: 1'b0, sync: 1'b0, recenter: 1'b0, comma: 1'b1,
    kchar: 4'h0, raw8: 4'h0, raw9: 4'h0, mf: 4'h0, irq: 1'b0, rdata: 32'h00000000
  };

  smc_state_s r;
  smc_state_s n;
  logic [PIN_W-1:0] pin_raw;
  logic [NCH-1:0] fail_now;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;

  assign pin_raw = {factory_test_enable_i, comma_align_enable_i, chip_reset_low_i,
                    lane_clock_sync_i, pattern_test_enable_i, serial_loopback_enable_i,
                    standby_i, op_mode_select_bit1_i, op_mode_select_bit0_i, coding_enable_i};

  // ---------------------------------------------------------------
  // Multifunction selection
  // ---------------------------------------------------------------
  function automatic logic mf_pick(input logic [1:0] sel, input logic hstl, input logic loss_of_signal,
                                   input logic cf, input logic pass, input logic pat_on);
    case (sel)
      MF_SIGTYPE: mf_pick = hstl;
      MF_LOS: mf_pick = loss_of_signal;
      MF_COMMA: mf_pick = cf;
      MF_PATTERN: mf_pick = pass & pat_on;
      default: mf_pick = 1'b0;
    endcase
  endfunction : mf_pick

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.s1 = pin_raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < PIN_W; i++)
    begin
      if (r.s2[i] == r.s3[i])
        n.pins[i] = r.s3[i];
    end
    case (r.pins[P_MODE1:P_MODE0])
      CFG_TRX: n.mode = SMC_MODE_TRX;
      CFG_TX: n.mode = SMC_MODE_TX;
      CFG_RX: n.mode = SMC_MODE_RX;
      CFG_RPT: n.mode = SMC_MODE_RPT;
      default: n.mode = SMC_MODE_TRX;
    endcase
    n.txp = (n.mode != SMC_MODE_RX);
    n.rxp = (n.mode != SMC_MODE_TX);
    n.rpt = (n.mode == SMC_MODE_RPT);
    n.enc = r.pins[P_CODE];
    n.lowp = ~r.pins[P_STBY];
    n.loop = r.pins[P_LOOP+NCH-1:P_LOOP];
    n.pat = r.pins[P_PAT];
    n.sync = r.pins[P_SYNC];
    n.recenter = ~r.pins[P_RST];
    n.comma = r.pins[P_COMMA];
    n.kchar = r.pins[P_CODE] ? tx_control_char_request_i : 4'h0;
    n.raw8 = r.pins[P_CODE] ? 4'h0 : tx_control_char_request_i;
    n.raw9 = r.pins[P_CODE] ? 4'h0 : tx_tenth_bit_i;
    for (int i = 0; i < NCH; i++)
    begin
      n.mf[i] = mf_pick(r.mf_sel[2*i+:2], signal_type_hstl_i, loss_of_signal_i[i],
                        comma_found_i[i], pattern_check_pass_i[i], r.pins[P_PAT]);
    end
    fail_now = r.pins[P_PAT] ? ~pattern_check_pass_i : 4'h0;
    events = {fail_now & ~r.prev_fail, comma_found_i & ~r.prev_comma, loss_of_signal_i & ~r.prev_los};
    n.prev_los = loss_of_signal_i;
    n.prev_comma = comma_found_i;
    n.prev_fail = fail_now;
    clr = (reg_wr_i && reg_addr_i == A_IRQ_CLR) ? reg_wdata_i[IRQ_W-1:0] : 12'h000;
    n.irq_stat = (r.irq_stat & ~clr) | events;
    if (!r.pins[P_RST])
      n.irq_stat = 12'h000;
    if (reg_wr_i && reg_addr_i == A_MF_SEL)
      n.mf_sel = reg_wdata_i[7:0];
    if (reg_wr_i && reg_addr_i == A_IRQ_EN)
      n.irq_en = reg_wdata_i[IRQ_W-1:0];
    n.irq = |(n.irq_stat & n.irq_en);
    n.rdata = 32'h00000000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        A_MF_SEL: n.rdata = {24'h000000, r.mf_sel};
        A_IRQ_STAT: n.rdata = {20'h00000, r.irq_stat};
        A_IRQ_EN: n.rdata = {20'h00000, r.irq_en};
        A_PINS: n.rdata = {19'h00000, r.pins};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      r <= RESET_STATE;
    else
      r <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o = r.rdata;
  assign encoder_enable_o = r.enc;
  assign decoder_enable_o = r.enc;
  assign tx_path_enable_o = r.txp;
  assign rx_path_enable_o = r.rxp;
  assign repeater_o = r.rpt;
  assign low_power_o = r.lowp;
  assign loopback_o = r.loop;
  assign pattern_gen_enable_o = r.pat;
  assign pattern_check_enable_o = r.pat;
  assign tx_clock_from_lane_a_o = r.sync;
  assign rx_clock_from_lane_a_o = r.sync;
  assign buffer_recenter_o = r.recenter;
  assign comma_align_o = r.comma;
  assign tx_kchar_o = r.kchar;
  assign tx_raw_bit8_o = r.raw8;
  assign tx_raw_bit9_o = r.raw9;
  assign multifunction_output_o = r.mf;
  assign irq_o = r.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_agree(int b);
    r.s2[b] == r.s3[b];
  endsequence

  property p_code;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_agree(P_CODE) |-> ##2 (encoder_enable_o == $past(r.s3[P_CODE], 2)) && decoder_enable_o == encoder_enable_o;
  endproperty
  a_code: assert property (p_code) else $error("coding enable not followed");

  property p_mode;
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##2 (tx_path_enable_o == ($past(r.pins[P_MODE1:P_MODE0], 1) != CFG_RX))
      && (rx_path_enable_o == ($past(r.pins[P_MODE1:P_MODE0], 1) != CFG_TX))
      && (repeater_o == ($past(r.pins[P_MODE1:P_MODE0], 1) == CFG_RPT)) && $onehot(r.mode);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");

  property p_stby;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_agree(P_STBY) ##1 s_agree(P_STBY) |=> low_power_o == ~$past(r.s3[P_STBY], 2);
  endproperty
  a_stby: assert property (p_stby) else $error("standby not followed");

  property p_loop;
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 loopback_o == $past(r.pins[P_LOOP+NCH-1:P_LOOP]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not followed");

  property p_mf_pat;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (r.mf_sel[1:0] == MF_PATTERN) |=> multifunction_output_o[0] == $past(pattern_check_pass_i[0] & r.pins[P_PAT]);
  endproperty
  a_mf_pat: assert property (p_mf_pat) else $error("pattern pass not shown");

  property p_mf_los;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (r.mf_sel[3:2] == MF_LOS) |=> multifunction_output_o[1] == $past(loss_of_signal_i[1]);
  endproperty
  a_mf_los: assert property (p_mf_los) else $error("loss of signal not shown");

  property p_pat;
    @(posedge core_clk_i) disable iff (!nrst_i)
    $rose(r.pins[P_PAT]) |=> pattern_gen_enable_o && pattern_check_enable_o;
  endproperty
  a_pat: assert property (p_pat) else $error("pattern test not inserted");

  property p_sync;
    @(posedge core_clk_i) disable iff (!nrst_i)
    $changed(r.pins[P_SYNC]) |=> tx_clock_from_lane_a_o == $past(r.pins[P_SYNC]) && rx_clock_from_lane_a_o == tx_clock_from_lane_a_o;
  endproperty
  a_sync: assert property (p_sync) else $error("lane clock sync wrong");

  property p_rst;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !r.pins[P_RST] |=> buffer_recenter_o && r.irq_stat == 12'h000 && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("chip reset not acted on");

  property p_comma;
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 comma_align_o == $past(r.pins[P_COMMA]);
  endproperty
  a_comma: assert property (p_comma) else $error("comma align not followed");

  property p_default;
    @(posedge core_clk_i)
    !nrst_i |=> r.pins == PIN_DEFAULT;
  endproperty
  a_default: assert property (p_default) else $error("pin defaults wrong");

  property p_kchar;
    @(posedge core_clk_i) disable iff (!nrst_i)
    r.pins[P_CODE] |=> tx_raw_bit9_o == 4'h0 && tx_kchar_o == $past(tx_control_char_request_i);
  endproperty
  a_kchar: assert property (p_kchar) else $error("control character request wrong");

  property p_filter;
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 ((r.pins ^ $past(r.pins)) & ($past(r.s2) ^ $past(r.s3))) == 13'h0000
      && ((r.pins ^ $past(r.s3)) & ~($past(r.s2) ^ $past(r.s3))) == 13'h0000;
  endproperty
  a_filter: assert property (p_filter) else $error("pin changed without agreement");

  property p_irq_set;
    @(posedge core_clk_i) disable iff (!nrst_i)
    r.pins[P_RST] && (events != 12'h000) |=> (r.irq_stat & $past(events)) == $past(events);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("status event lost");
endmodule : smc_top
`default_nettype wire

// File: pkg/smc_pkg.sv
// Constants and types of the serdes mode control block
// Behaviour
// - Coding enable high turns on encoder and decoder; low bypasses both.
// - Mode select 00 transceiver, 01 transmit-only, 10 receive-only, 11 repeater.
// - Standby low holds low-power state; high runs normally.
// - Per-lane loopback high routes serial transmit back to own receive.
// - Multifunction output shows signaling type, loss of signal, comma or pattern status.
// - Pattern enable inserts generator and comparator into all lanes.
// - Pattern pass appears on multifunction outputs only while that function is selected and pattern enable is high.
// - Lane clock sync high clocks all lanes from lane A clocks.
// - Chip reset low recenters skew and sync buffers and clears management flags.
// - Comma align enable high turns on comma detection and byte alignment.
// - Open control inputs default to their pull levels.
// - With coding, ninth bit requests control character, tenth ignored; else raw bits.
// - Lane clock sync low clocks each lane from its own clock.
package smc_pkg;
  localparam int NCH = 4;
  localparam int PIN_W = 13;
  localparam int P_CODE = 0;
  localparam int P_MODE0 = 1;
  localparam int P_MODE1 = 2;
  localparam int P_STBY = 3;
  localparam int P_LOOP = 4;
  localparam int P_PAT = 8;
  localparam int P_SYNC = 9;
  localparam int P_RST = 10;
  localparam int P_COMMA = 11;
  localparam int P_TEST = 12;
  localparam logic [12:0] PIN_DEFAULT = 13'h0C09;
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_MF_SEL = 8'h00;
  localparam logic [7:0] A_IRQ_STAT = 8'h04;
  localparam logic [7:0] A_IRQ_EN = 8'h08;
  localparam logic [7:0] A_IRQ_CLR = 8'h0C;
  localparam logic [7:0] A_PINS = 8'h10;
  localparam logic [7:0] MF_SEL_RESET = 8'h00;
  localparam logic [1:0] MF_SIGTYPE = 2'h0;
  localparam logic [1:0] MF_LOS = 2'h1;
  localparam logic [1:0] MF_COMMA = 2'h2;
  localparam logic [1:0] MF_PATTERN = 2'h3;
  localparam logic [1:0] CFG_TRX = 2'h0;
  localparam logic [1:0] CFG_TX = 2'h1;
  localparam logic [1:0] CFG_RX = 2'h2;
  localparam logic [1:0] CFG_RPT = 2'h3;
  localparam int IRQ_W = 12;
  localparam int IRQ_LOS_LSB = 0;
  localparam int IRQ_COMMA_LSB = 4;
  localparam int IRQ_FAIL_LSB = 8;
  typedef enum logic [3:0] {
    SMC_MODE_TRX = 4'b0001,
    SMC_MODE_TX = 4'b0010,
    SMC_MODE_RX = 4'b0100,
    SMC_MODE_RPT = 4'b1000
  } smc_mode_e;
endpackage : smc_pkg

// File: tb/smc_strap_model.sv
// Board strapping model that drives the control pins of the mode control block
`timescale 1ns/1ps
`default_nettype none
module smc_strap_model
(
  input wire logic [smc_pkg::PIN_W-1:0] vals_i,
  input wire logic float_i,
  output logic [smc_pkg::PIN_W-1:0] pins_o
);
  import smc_pkg::*;
  // ---------------------------------------------
  // Pin levels, open pins settle to pull levels
  // ---------------------------------------------
  always_comb
  begin
    if (float_i)
    begin
      pins_o = PIN_DEFAULT;
    end
    else
    begin
      pins_o = vals_i;
    end
    pins_o[P_TEST] = 1'b0;
  end
endmodule : smc_strap_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the serdes mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import smc_pkg::*;
  typedef struct packed {logic flt; logic [12:0] pin; logic [15:0] outs;} smc_row_s;
  logic core_clk_i, nrst_i, flt, hstl, reg_wr_i, reg_rd_i;
  logic [12:0] val, pins;
  logic [3:0] loss_of_signal, cf, pass, kreq, tenth, lpo, mfo, kch, raw8, raw9;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic enc, dec, txp, rxp, rpt, lp, pg, pc, txa, rxa, rec, cma, irq;
  logic [15:0] outs;
  logic coding;
  int n_mismatch = 0;
  int checks_done = 0;
  smc_row_s rows [8] = '{'{1'b0, 13'h0C09, 16'hF001}, '{1'b0, 13'h0C0B, 16'hE001}, '{1'b0, 13'h0C0D, 16'hD001},
    '{1'b0, 13'h0C0F, 16'hF801}, '{1'b0, 13'h0C00, 16'h3401}, '{1'b0, 13'h0D59, 16'hF171},
    '{1'b1, 13'h0000, 16'hF001}, '{1'b0, 13'h0209, 16'hF00E}};
  assign outs = {enc, dec, txp, rxp, rpt, lp, lpo, pg, pc, txa, rxa, rec, cma};
  always #4 core_clk_i = ~core_clk_i;
  smc_strap_model u_strap (.vals_i(val), .float_i(flt), .pins_o(pins));
  smc_top u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .coding_enable_i(pins[P_CODE]),
    .op_mode_select_bit0_i(pins[P_MODE0]), .op_mode_select_bit1_i(pins[P_MODE1]), .standby_i(pins[P_STBY]),
    .serial_loopback_enable_i(pins[P_LOOP+3:P_LOOP]), .pattern_test_enable_i(pins[P_PAT]),
    .lane_clock_sync_i(pins[P_SYNC]), .chip_reset_low_i(pins[P_RST]), .comma_align_enable_i(pins[P_COMMA]),
    .factory_test_enable_i(pins[P_TEST]), .signal_type_hstl_i(hstl), .loss_of_signal_i(loss_of_signal),
    .comma_found_i(cf), .pattern_check_pass_i(pass), .tx_control_char_request_i(kreq), .tx_tenth_bit_i(tenth),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .encoder_enable_o(enc), .decoder_enable_o(dec), .tx_path_enable_o(txp),
    .rx_path_enable_o(rxp), .repeater_o(rpt), .low_power_o(lp), .loopback_o(lpo), .pattern_gen_enable_o(pg),
    .pattern_check_enable_o(pc), .tx_clock_from_lane_a_o(txa), .rx_clock_from_lane_a_o(rxa),
    .buffer_recenter_o(rec), .comma_align_o(cma), .tx_kchar_o(kch), .tx_raw_bit8_o(raw8),
    .tx_raw_bit9_o(raw9), .multifunction_output_o(mfo), .irq_o(irq));
  // ---------------------------------------------
  // Register port and timing helpers
  // ---------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : settle
  task automatic set_pins(input logic f, input logic [12:0] v);
    @(posedge core_clk_i);
    flt <= f;
    val <= v;
    settle(8);
  endtask : set_pins
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ---------------------------------------------
  // Stimulus
  // ---------------------------------------------
  initial
  begin
    core_clk_i = 1'b0; nrst_i = 1'b0; flt = 1'b1; val = 13'h0000; hstl = 1'b1; loss_of_signal = 4'h3; cf = 4'h6;
    pass = 4'h9; kreq = 4'hA; tenth = 4'h5; reg_addr_i = 8'h00; reg_wdata_i = 32'h0; reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    settle(2);
    `CHK(outs, 16'hF001)
    `CHK(mfo, 4'hF)
    `CHK(irq, 1'b0)
    rd(A_PINS);
    `CHK(d, {19'h0, PIN_DEFAULT})
    wr(A_MF_SEL, 32'hE4);
    settle(3);
    `CHK(mfo, 4'b0111)
    for (int s = 0; s < 4; s++)
    begin
      wr(A_MF_SEL, {24'h0, {4{s[1:0]}}});
      settle(3);
      `CHK(mfo, s == 0 ? 4'hF : s == 1 ? loss_of_signal : s == 2 ? cf : 4'h0)
    end
    set_pins(1'b0, 13'h0D09);
    `CHK(mfo, pass)
    rd(A_IRQ_STAT);
    `CHK(d, 32'h663)
    set_pins(1'b0, 13'h0C09);
    wr(A_IRQ_CLR, 32'hFFF);
    wr(A_IRQ_EN, 32'h001);
    @(posedge core_clk_i);
    loss_of_signal <= 4'h7;
    rd(A_IRQ_STAT);
    `CHK(d, 32'h004)
    `CHK(irq, 1'b0)
    wr(A_IRQ_EN, 32'h004);
    settle(1);
    `CHK(irq, 1'b1)
    wr(A_IRQ_STAT, 32'h0);
    wr(A_IRQ_CLR, 32'h004);
    settle(1);
    `CHK(irq, 1'b0)
    rd(A_IRQ_STAT);
    `CHK(d, 32'h0)
    rd(A_IRQ_CLR);
    `CHK(d, 32'h0)
    rd(8'h40);
    `CHK(d, 32'h0)
    rd(A_IRQ_EN);
    `CHK(d, 32'h004)
    @(posedge core_clk_i);
    cf <= 4'h7;
    rd(A_IRQ_STAT);
    `CHK(d, 32'h010)
    foreach (rows[i])
    begin
      set_pins(rows[i].flt, rows[i].pin);
      coding = rows[i].flt | rows[i].pin[P_CODE];
      `CHK(outs, rows[i].outs)
      `CHK({kch, raw8, raw9}, coding ? 12'hA00 : 12'h0A5)
      rd(A_PINS);
      `CHK(d[12:0], rows[i].flt ? PIN_DEFAULT : rows[i].pin)
    end
    rd(A_IRQ_STAT);
    `CHK(d, 32'h0)
    set_pins(1'b0, 13'h0C09);
    @(posedge core_clk_i);
    val <= 13'h0C01;
    @(posedge core_clk_i);
    val <= 13'h0C09;
    for (int c = 0; c < 8; c++)
    begin
      settle(1);
      `CHK(lp, 1'b0)
    end
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(A_MF_SEL);
    `CHK(d, {24'h0, MF_SEL_RESET})
    @(posedge core_clk_i);
    hstl <= 1'b0;
    settle(2);
    `CHK(mfo, 4'h0)
    close_out();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
